// ==== core/tw_slave.sv ====
// Purpose: Slave end: start/stop detect, address decode, ack and byte shifting
// Assumes: Master keeps clock quarter period well above sync delay
// Notes: Open-drain data; only ever pulls low, never touches the clock
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module tw_slave import tw_pkg::*; #(
  parameter int unsigned NV_CYC = NV_WRITE_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEn,
  tw_if.slave bus,
  input wire logic writeEnableLatch,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic txTake,
  output logic [2:0] target,
  output logic readDir,
  output logic standby,
  output logic nvBusy
);
  localparam int CNT_W = $clog2(NV_CYC + 1);
  logic [1:0] lineS; // Synced {clock, data}
  logic sclPrev_r; // Clock one cycle back
  logic sdaPrev_r; // Data one cycle back
  logic sclRise; // Clock rising edge
  logic sclFall; // Clock falling edge
  logic startSeen; // Start condition
  logic stopSeen; // Stop condition
  tw_slv_state_t state_r; // Protocol state
  logic [3:0] bitCnt_r; // Bits clocked in this byte
  logic [7:0] shift_r; // Receive shifter
  logic [7:0] txSh_r; // Transmit shifter
  logic sdaOe_r; // Pulling data low
  logic sdaOut_r; // Pull level, always low
  logic ackBit_r; // Master ack seen in read
  logic readSeq_r; // Current frame is a read
  logic wroteData_r; // Frame delivered write data
  logic [CNT_W-1:0] busyCnt_r; // Nonvolatile cycle timer
  logic addrMatch; // Address byte accepted
  logic deliver; // Data byte may be passed on

  // Pins cross into the clock domain first
  tw_sync #(.WIDTH(2)) u_sync (
    .clock(clock),
    .reset(reset),
    .clockEn(clockEn),
    .din({bus.scl, bus.sda}),
    .dout(lineS)
  );

  // Edge history for both lines
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else if (clockEn) begin
      sclPrev_r <= lineS[1];
      sdaPrev_r <= lineS[0];
    end
  end

  assign sclRise = lineS[1] & ~sclPrev_r;
  assign sclFall = ~lineS[1] & sclPrev_r;
  // Data moving while clock stays high is framing, never data
  assign startSeen = sclPrev_r & lineS[1] & sdaPrev_r & ~lineS[0];
  assign stopSeen = sclPrev_r & lineS[1] & ~sdaPrev_r & lineS[0];

  // Type field, known target, and no write cycle running
  assign addrMatch = (shift_r[TYPE_MSB:TYPE_LSB] == DEV_TYPE_ID)
    && tw_target_ok(shift_r[TGT_MSB:TGT_LSB])
    && !nvBusy;
  // Register writes always pass; memory and pot writes need the latch
  assign deliver = (target == TGT_CSR) || writeEnableLatch;

  // Main protocol engine
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      txSh_r <= 8'h00;
      sdaOe_r <= 1'b0;
      ackBit_r <= 1'b0;
      readSeq_r <= 1'b0;
      wroteData_r <= 1'b0;
      rxByte <= 8'h00;
      rxValid <= 1'b0;
      txTake <= 1'b0;
      target <= 3'h0;
      readDir <= 1'b0;
    end else if (clockEn) begin
      rxValid <= 1'b0;
      txTake <= 1'b0;
      if (startSeen) begin
        // A start always restarts, even mid-byte
        state_r <= S_ADDR;
        bitCnt_r <= 4'h0;
        sdaOe_r <= 1'b0;
        readSeq_r <= 1'b0;
        wroteData_r <= 1'b0;
      end else if (stopSeen) begin
        state_r <= S_IDLE;
        sdaOe_r <= 1'b0;
      end else begin
        unique case (state_r)
          S_IDLE: begin
            // Deaf to everything but a start
            sdaOe_r <= 1'b0;
          end
          S_ADDR, S_WRITE: begin
            if (sclRise) begin
              // Sample on rising clock, MSB first
              shift_r <= {shift_r[6:0], lineS[0]};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall && bitCnt_r == BYTE_BITS) begin
              bitCnt_r <= 4'h0;
              if (state_r == S_ADDR) begin
                if (addrMatch) begin
                  sdaOe_r <= 1'b1;
                  state_r <= S_AACK;
                  readDir <= shift_r[DIR_POS];
                  target <= shift_r[TGT_MSB:TGT_LSB];
                end else begin
                  // Leave the ack slot released and go deaf
                  state_r <= S_IDLE;
                end
              end else begin
                sdaOe_r <= 1'b1;
                state_r <= S_DACK;
                if (deliver) begin
                  rxByte <= shift_r;
                  rxValid <= 1'b1;
                  wroteData_r <= 1'b1;
                end
              end
            end
          end
          S_AACK: begin
            if (sclFall) begin
              if (readDir == DIR_READ) begin
                // First read bit goes out as the ack is let go
                txSh_r <= txByte;
                txTake <= 1'b1;
                sdaOe_r <= ~txByte[7];
                readSeq_r <= 1'b1;
                state_r <= S_READ;
              end else begin
                sdaOe_r <= 1'b0;
                state_r <= S_WRITE;
              end
            end
          end
          S_DACK: begin
            if (sclFall) begin
              sdaOe_r <= 1'b0;
              state_r <= S_WRITE;
            end
          end
          S_READ: begin
            if (sclRise) begin
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_r == BYTE_BITS) begin
                // Eighth bit done: hand data line to the master
                sdaOe_r <= 1'b0;
                bitCnt_r <= 4'h0;
                state_r <= S_RACK;
              end else begin
                txSh_r <= {txSh_r[6:0], 1'b0};
                sdaOe_r <= ~txSh_r[6];
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              ackBit_r <= ~lineS[0];
            end else if (sclFall) begin
              if (ackBit_r) begin
                txSh_r <= txByte;
                txTake <= 1'b1;
                sdaOe_r <= ~txByte[7];
                state_r <= S_READ;
              end else begin
                // No ack: stay off the bus until the next start
                state_r <= S_IDLE;
              end
            end
          end
          default: begin
            state_r <= S_IDLE;
            sdaOe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Standby after a read frame closes; any start wakes it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      standby <= 1'b0;
    end else if (clockEn) begin
      if (startSeen) begin
        standby <= 1'b0;
      end else if (stopSeen && readSeq_r) begin
        standby <= 1'b1;
      end
    end
  end

  // Nonvolatile cycle: any delivered write starts it at the stop.
  // Volatile pot writes also pay this wait; instruction bytes are not decoded here.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busyCnt_r <= '0;
      nvBusy <= 1'b0;
    end else if (clockEn) begin
      if (stopSeen && wroteData_r && !readSeq_r) begin
        busyCnt_r <= CNT_W'(NV_CYC - 1);
        nvBusy <= 1'b1;
      end else if (busyCnt_r != '0) begin
        busyCnt_r <= busyCnt_r - 1'b1;
      end else begin
        nvBusy <= 1'b0;
      end
    end
  end

  // Open drain: the level when pulling is always low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sdaOut_r <= 1'b0;
    end else if (clockEn) begin
      sdaOut_r <= 1'b0;
    end
  end

  assign bus.sdaSOe = sdaOe_r;
  assign bus.sdaSOut = sdaOut_r;
endmodule // tw_slave

// ==== core/tw_pkg.sv ====
// Purpose: Shared constants, types and decode for the two-wire slave front end and its master
// Assumes: 40 MHz system clock on both ends
// Notes: How it works list below; the items carry no tags for where each is done
//
// How it works
// - Master starts transfers and makes the clock
// - Data changes only while clock is low
// - Device leaves data line released after power-up
// - Start is data falling while clock high
// - Device ignores traffic until a start
// - Master ends with stop: data rising, clock high
// - Stop after a read puts device in standby
// - Stop only after transmitter released data
// - Ninth clock: receiver pulls data low
// - Ack address only when type field matches
// - On writes, device acks every following byte
// - Reads: eight bits, release, sample ack, continue
// - No ack ends sending; master then stops
// - Write enable latch must be set first (the slave passes register target writes without it)
// - Every operation opens with the address byte
// - Device type field must equal 1010
// - Target select: 000 memory, 010 register, 111 pots
// - Direction bit: 1 read, 0 write
// - No address ack during nonvolatile write cycle
package tw_pkg;
  // Address byte layout
  localparam logic [3:0] DEV_TYPE_ID = 4'ha;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int TGT_MSB = 3;
  localparam int TGT_LSB = 1;
  localparam int DIR_POS = 0;
  localparam logic DIR_READ = 1'h1;
  // Internal targets
  localparam logic [2:0] TGT_MEM = 3'h0;
  localparam logic [2:0] TGT_CSR = 3'h2;
  localparam logic [2:0] TGT_POT = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Timing
  localparam int CLK_NS = 25;
  localparam int NV_WRITE_MS = 5;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * 1000000 / CLK_NS;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  // Master register map and fields
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CMD_START_BIT = 8;
  localparam int CMD_STOP_BIT = 9;
  localparam int CMD_READ_BIT = 10;
  localparam int CMD_NACK_BIT = 11;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ACK_BIT = 1;
  localparam int ST_RX_LSB = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b010, S_WRITE = 3'b011,
    S_DACK = 3'b100, S_READ = 3'b101, S_RACK = 3'b110
  } tw_slv_state_t;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_START = 2'b01, M_BIT = 2'b10, M_STOP = 2'b11
  } tw_mst_state_t;
  // Internal select values the device answers to
  function automatic logic tw_target_ok(input logic [2:0] sel);
    return (sel == TGT_MEM) || (sel == TGT_CSR) || (sel == TGT_POT);
  endfunction
endpackage

// ==== core/tw_if.sv ====
// Purpose: Two-wire link between master and slave ends
// Assumes: Data line is open drain with a pull-up
// Notes: Wire level is resolved here from the enables
`timescale 1ns/1ps
interface tw_if;
  logic scl; // Serial clock, master only
  logic sdaMOe; // Master pulls data
  logic sdaMOut; // Master data level when pulling
  logic sdaSOe; // Slave pulls data
  logic sdaSOut; // Slave data level when pulling
  logic sda; // Resolved data line
  // Pull-up wins unless an end pulls low
  assign sda = ~((sdaMOe & ~sdaMOut) | (sdaSOe & ~sdaSOut));
  modport master (output scl, output sdaMOe, output sdaMOut, input sda);
  modport slave (input scl, input sda, output sdaSOe, output sdaSOut);
endinterface

// ==== core/tw_sync.sv ====
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes: First stage is read only by the second
`timescale 1ns/1ps
module tw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r; // First stage
  // Idle bus lines rest high, so reset to ones
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_r <= '1;
      dout <= '1;
    end else if (clockEn) begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // tw_sync

// ==== core/tw_master.sv ====
// Purpose: Master end: byte-level two-wire engine driven from AHB-Lite registers
// Assumes: Single word transfers only; the far slave never stretches the clock
// Notes: Makes the serial clock by dividing the system clock
`timescale 1ns/1ps
module tw_master import tw_pkg::*; #(
  parameter int QUARTER = SCL_QUARTER_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEn,
  tw_if.master bus,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  logic sdaS; // Synced data line
  logic wrPend_r; // Write data phase pending
  logic [7:0] addrQ_r; // Captured address
  tw_mst_state_t state_r; // Engine state
  logic [1:0] phase_r; // Quarter of the bit
  logic [15:0] qCnt_r; // Quarter timer
  logic [3:0] bitIdx_r; // Bit within byte, 8 = ack
  logic [7:0] txB_r; // Byte to send
  logic [7:0] rxB_r; // Byte received
  logic cmdStop_r; // Stop after this byte
  logic cmdRead_r; // Receive instead of send
  logic cmdNack_r; // Withhold ack on receive
  logic ackSeen_r; // Slave acked last sent byte
  logic sclOut_r; // Serial clock out
  logic sdaOe_r; // Pulling data low
  logic sdaOut_r; // Pull level, always low
  logic tick; // End of a quarter
  logic busy; // Engine running

  tw_sync #(.WIDTH(1)) u_sync (
    .clock(clock),
    .reset(reset),
    .clockEn(clockEn),
    .din(bus.sda),
    .dout(sdaS)
  );

  assign tick = (qCnt_r == 16'(QUARTER - 1));
  assign busy = (state_r != M_IDLE);

  // Read mux shared by the bus slave
  function automatic logic [31:0] rdMux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == STAT_OFS) begin
      v[ST_BUSY_BIT] = busy;
      v[ST_ACK_BIT] = ackSeen_r;
      v[ST_RX_LSB +: 8] = rxB_r;
    end
    return v;
  endfunction

  // AHB-Lite slave: zero wait, read data registered at the address phase
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wrPend_r <= 1'b0;
      addrQ_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clockEn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
        wrPend_r <= hwrite;
        addrQ_r <= haddr;
        hrdata <= hwrite ? 32'h0000_0000 : rdMux(haddr);
      end else begin
        wrPend_r <= 1'b0;
      end
    end
  end

  // Byte engine; a command write while busy is dropped.
  // Software writes the latch byte to the register target before pot or memory writes.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= M_IDLE;
      phase_r <= 2'h0;
      qCnt_r <= 16'h0000;
      bitIdx_r <= 4'h0;
      txB_r <= 8'h00;
      rxB_r <= 8'h00;
      cmdStop_r <= 1'b0;
      cmdRead_r <= 1'b0;
      cmdNack_r <= 1'b0;
      ackSeen_r <= 1'b0;
      sclOut_r <= 1'b1;
      sdaOe_r <= 1'b0;
    end else if (clockEn) begin
      if (state_r == M_IDLE) begin
        qCnt_r <= 16'h0000;
        phase_r <= 2'h0;
        bitIdx_r <= 4'h0;
        if (wrPend_r && addrQ_r == CMD_OFS) begin
          txB_r <= hwdata[7:0];
          cmdStop_r <= hwdata[CMD_STOP_BIT];
          cmdRead_r <= hwdata[CMD_READ_BIT];
          cmdNack_r <= hwdata[CMD_NACK_BIT];
          state_r <= hwdata[CMD_START_BIT] ? M_START : M_BIT;
        end
      end else begin
        qCnt_r <= tick ? 16'h0000 : qCnt_r + 16'h0001;
        if (tick) begin
          phase_r <= phase_r + 2'h1;
          unique case (state_r)
            M_START: begin
              // Release, clock high, data falls, clock low
              unique case (phase_r)
                2'h0: sdaOe_r <= 1'b0;
                2'h1: sclOut_r <= 1'b1;
                2'h2: sdaOe_r <= 1'b1;
                2'h3: begin
                  sclOut_r <= 1'b0;
                  state_r <= M_BIT;
                end
              endcase
            end
            M_BIT: begin
              unique case (phase_r)
                2'h0: begin
                  // Data set only while clock is low
                  if (bitIdx_r == BYTE_BITS) begin
                    sdaOe_r <= cmdRead_r & ~cmdNack_r;
                  end else begin
                    sdaOe_r <= ~cmdRead_r & ~txB_r[7];
                  end
                end
                2'h1: sclOut_r <= 1'b1;
                2'h2: begin
                  if (bitIdx_r == BYTE_BITS) begin
                    ackSeen_r <= ~sdaS;
                  end else if (cmdRead_r) begin
                    rxB_r <= {rxB_r[6:0], sdaS};
                  end
                end
                2'h3: begin
                  sclOut_r <= 1'b0;
                  if (bitIdx_r == BYTE_BITS) begin
                    state_r <= cmdStop_r ? M_STOP : M_IDLE;
                  end else begin
                    bitIdx_r <= bitIdx_r + 4'h1;
                    txB_r <= {txB_r[6:0], 1'b0};
                  end
                end
              endcase
            end
            M_STOP: begin
              // Slave let go at the ack fall, so pulling low is safe
              unique case (phase_r)
                2'h0: sdaOe_r <= 1'b1;
                2'h1: sclOut_r <= 1'b1;
                2'h2: sdaOe_r <= 1'b0;
                2'h3: state_r <= M_IDLE;
              endcase
            end
            default: state_r <= M_IDLE;
          endcase
        end
      end
    end
  end

  // Open drain: the level when pulling is always low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sdaOut_r <= 1'b0;
    end else if (clockEn) begin
      sdaOut_r <= 1'b0;
    end
  end

  assign bus.scl = sclOut_r;
  assign bus.sdaMOe = sdaOe_r;
  assign bus.sdaMOut = sdaOut_r;
endmodule // tw_master

// ==== tb/tw_link_assertions.sv ====
// Purpose: Wire-level checks between the master and slave ends of the two-wire link
// Assumes: One clock domain; reset is asynchronous and active high
// Notes: Sees only the link signals; instanced beside the link in the bench
`timescale 1ns/1ps
module tw_link_assertions #(
  parameter int QUARTER = 25
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaMOe,
  input wire logic sdaMOut,
  input wire logic sdaSOe,
  input wire logic sdaSOut
);
  default clocking dcb @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] lowCnt_r; // Cycles the serial clock has stayed low
  // Low-time counter; saturates so a long low stretch cannot wrap to a small value
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lowCnt_r <= 8'h00;
    end else if (scl) begin
      lowCnt_r <= 8'h00;
    end else if (lowCnt_r != 8'hff) begin
      lowCnt_r <= lowCnt_r + 8'h01;
    end
  end
  // Data moving while the clock is high marks frame edges
  sequence startSeen;
    scl && $fell(sda);
  endsequence
  sequence stopSeen;
    scl && $rose(sda);
  endsequence
  a_start_clock_high: assert property (startSeen |-> scl [*8])
    else $error("Serial clock dropped right after a start");
  a_deaf_after_stop: assert property (stopSeen |=> !sdaSOe [*8])
    else $error("Slave drove data right after a stop");
  a_stop_released: assert property (stopSeen |-> !$past(sdaSOe))
    else $error("Stop seen while slave still held data");
  a_slave_stable_high: assert property (scl && $past(scl) |-> $stable(sdaSOe))
    else $error("Slave moved data while clock high");
  a_ack_after_fall: assert property ($rose(sdaSOe) |-> !scl && !$past(scl, 2))
    else $error("Slave began driving too soon after clock fall");
  a_reset_quiet: assert property ($fell(reset) |-> (!sdaSOe && !sdaMOe && scl) [*4])
    else $error("Link not idle after reset release");
  a_slave_open_drain: assert property (sdaSOe |-> !sdaSOut)
    else $error("Slave drove data high");
  a_master_open_drain: assert property (sdaMOe |-> !sdaMOut)
    else $error("Master drove data high");
  a_scl_low_time: assert property ($rose(scl) |-> int'(lowCnt_r) >= 2 * QUARTER - 2)
    else $error("Serial clock low phase too short");
endmodule // tw_link_assertions

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench joining the two-wire master and slave ends
// Assumes: One 40 MHz clock; the master is ordered over AHB-Lite
// Notes: Table rows first, then polling, restart, reads and reset cases
`timescale 1ns/1ps
module tb_top import tw_pkg::*;;
  localparam int NV = 1500; // Long enough to poll the slave during it
  localparam int LIMIT = 80000; // Cycle ceiling for the whole run
  localparam logic [3:0] ST = 4'h1; // Start before byte
  localparam logic [3:0] SP = 4'h2; // Stop after byte
  localparam logic [3:0] RD = 4'h4; // Receive a byte
  localparam logic [3:0] NK = 4'h8; // Refuse the received byte
  typedef struct packed {logic [7:0] addr; logic write_enable_latch; logic ack;} tw_row_t;
  logic clock, reset, hsel, hwrite, hreadyout, hresp, write_enable_latch, rxValid, txTake;
  logic readDir, standby, nvBusy;
  logic [7:0] haddr, txByte, rxByte;
  logic [1:0] htrans;
  logic [2:0] target;
  logic [31:0] hwdata, hrdata, rd;
  logic [8:0] wireSh; // Last nine bits sampled on the wire
  int miscompares, checksDone, cyc, delivered, takes, n;
  tw_row_t r;
  // Address, latch level, expected address ack
  tw_row_t rows [11] = '{'{8'ha0, 1'b1, 1'b1}, '{8'ha0, 1'b0, 1'b1}, '{8'ha4, 1'b0, 1'b1},
    '{8'hae, 1'b1, 1'b1}, '{8'hae, 1'b0, 1'b1}, '{8'ha1, 1'b0, 1'b1}, '{8'ha5, 1'b0, 1'b1},
    '{8'haf, 1'b0, 1'b1}, '{8'hb0, 1'b1, 1'b0}, '{8'ha2, 1'b1, 1'b0}, '{8'hac, 1'b1, 1'b0}};
  tw_if link();
  tw_master #(.QUARTER(25)) tw_master_i (.clock(clock), .reset(reset), .clockEn(1'b1),
    .bus(link.master), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));
  tw_slave #(.NV_CYC(NV)) tw_slave_i (.clock(clock), .reset(reset), .clockEn(1'b1),
    .bus(link.slave), .writeEnableLatch(write_enable_latch), .txByte(txByte), .rxByte(rxByte),
    .rxValid(rxValid), .txTake(txTake), .target(target), .readDir(readDir),
    .standby(standby), .nvBusy(nvBusy));
  tw_link_assertions #(.QUARTER(25)) tw_link_assertions_i (.clock(clock), .reset(reset),
    .scl(link.scl), .sda(link.sda), .sdaMOe(link.sdaMOe), .sdaMOut(link.sdaMOut),
    .sdaSOe(link.sdaSOe), .sdaSOut(link.sdaSOut));
  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Pulse counters and hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rxValid === 1'b1) delivered <= delivered + 1;
    if (txTake === 1'b1) takes <= takes + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      results();
    end
  end
  // Bits as the receiver sees them, first bit ends up highest
  always @(posedge link.scl) wireSh <= {wireSh[7:0], link.sda};
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One single AHB transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Order one byte, then poll status until the engine is idle
  task automatic cmd(input logic [3:0] fl, input logic [7:0] b);
    ahb(1'b1, CMD_OFS, {20'h0, fl, b});
    do ahb(1'b0, STAT_OFS, 32'h0); while (rd[ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic waitNv();
    while (nvBusy !== 1'b0) @(posedge clock);
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    hsel = 1'b1;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    write_enable_latch = 1'b0;
    txByte = 8'h96;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    ahb(1'b0, STAT_OFS, 32'h0);
    check("status after reset", rd, 32'h0);
    check("okay response", hresp, 1'b0);
    check("slave after reset", {standby, nvBusy, link.sdaSOe}, 3'h0);
    ahb(1'b0, 8'h08, 32'h0);
    check("unmapped read", rd, 32'h0);
    // Ordinary frames: address byte, then one data byte or one read byte
    foreach (rows[i]) begin
      r = rows[i];
      waitNv();
      write_enable_latch <= r.write_enable_latch;
      n = delivered;
      cmd(ST, r.addr);
      check("address ack", rd[ST_ACK_BIT], r.ack);
      check("address on wire", wireSh, {r.addr, ~r.ack});
      if (r.ack) begin
        check("target", target, r.addr[3:1]);
        check("direction", readDir, r.addr[0]);
      end
      if (r.addr[0] === 1'b1) begin
        cmd(RD | NK | SP, 8'h00);
        check("read byte", rd[15:8], txByte);
        // The stop raises the clock once more while data is held low
        check("read on wire", wireSh, {txByte[6:0], 1'b1, 1'b0});
      end else begin
        cmd(SP, 8'h3c);
        check("data ack", rd[ST_ACK_BIT], r.ack);
        check("delivered", delivered - n, r.ack && (r.write_enable_latch || r.addr[3:1] == TGT_CSR));
      end
    end
    // Poll during the nonvolatile cycle: refused until it ends
    waitNv();
    write_enable_latch <= 1'b1;
    cmd(ST, 8'ha0);
    cmd(SP, 8'h55);
    check("nv busy", nvBusy, 1'b1);
    check("rx byte", rxByte, 8'h55);
    cmd(ST, 8'ha0);
    check("poll refused", rd[ST_ACK_BIT], 1'b0);
    cmd(SP, 8'hff);
    waitNv();
    // Restart mid-frame, then two read bytes, acked then refused
    n = takes;
    cmd(ST, 8'ha4);
    cmd(ST, 8'ha5);
    check("restart select", {target, readDir}, 4'h5);
    cmd(RD, 8'h00);
    check("first read ack", wireSh, {txByte, 1'b0});
    cmd(RD | NK | SP, 8'h00);
    check("bytes taken", takes - n, 2);
    check("standby", standby, 1'b1);
    cmd(ST, 8'hb0);
    check("standby cleared", standby, 1'b0);
    cmd(SP, 8'h00);
    // Reset in mid-frame leaves both ends released
    ahb(1'b1, CMD_OFS, {20'h0, ST, 8'ha0});
    repeat (300) @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    check("lines in reset", {link.scl, link.sdaSOe, link.sdaMOe}, 3'h4);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    cmd(ST, 8'ha4);
    check("ack after reset", rd[ST_ACK_BIT], 1'b1);
    cmd(SP, 8'h00);
    check("idle lines", {link.scl, link.sda}, 2'h3);
    results();
  end
endmodule // tb_top
